// file: rtcc_defines.vh
`ifndef RTCC_DEFINES_VH
`define RTCC_DEFINES_VH
`define RTCC_ADR_CAP0      8'h00
`define RTCC_ADR_CAP5      8'h05
`define RTCC_ADR_CTRL      8'h06
`define RTCC_ADR_OSC       8'h07
`define RTCC_ADR_ALM0      8'h08
`define RTCC_ADR_ALM5      8'h0d
`define RTCC_CTRL_RUN      4
`define RTCC_CTRL_AEN      3
`define RTCC_CTRL_ALARM_FLAG     2
`define RTCC_CTRL_SET      1
`define RTCC_CTRL_CAP      0
`define RTCC_OSC_AGC       7
`define RTCC_OSC_CRYSTAL_MODE_SELECT     6
`define RTCC_OSC_BIAS      5
`define RTCC_OSC_VALID     4
`define RTCC_OSC_BACKUP    0
`define RTCC_CAP_RESET     8'hff
`define RTCC_ALM_RESET     8'hff
`define RTCC_BYTES         6
`define RTCC_TW            47
`endif

// file: rtcc_top.v
`timescale 1ns/10ps
`include "rtcc_defines.vh"
module rtcc_top (
    core_clk,
    sys_rst,
    slow_clock,
    clock_valid,
    backup_supply_indicator,
    addr_wr,
    data_wr,
    data_rd,
    wdata,
    rdata,
    gain_control_enable,
    crystal_mode_select,
    bias_double_enable,
    alarm_flag,
    timer_value
);
    input  wire        core_clk;
    input  wire        sys_rst;
    input  wire        slow_clock;
    input  wire        clock_valid;
    input  wire        backup_supply_indicator;
    input  wire        addr_wr;
    input  wire        data_wr;
    input  wire        data_rd;
    input  wire [7:0]  wdata;
    output reg  [7:0]  rdata;
    output wire        gain_control_enable;
    output wire        crystal_mode_select;
    output wire        bias_double_enable;
    output wire        alarm_flag;
    output wire [46:0] timer_value;

    reg  [7:0]  address_q;
    reg         agc_q;
    reg         crystal_mode_select_q;
    reg         bias_q;
    reg         run_q;
    reg         aen_q;
    reg         alarm_flag_q;
    reg         set_q;
    reg         cap_q;
    reg  [7:0]  capture_bytes_q [0:5];
    reg  [7:0]  alarm_bytes_q [0:5];
    reg  [46:0] timer_q;
    reg  [2:0]  slow_sync_q;
    reg  [1:0]  vld_sync_q;
    reg  [1:0]  bat_sync_q;
    wire [47:0] cap_flat;
    wire [47:0] alm_flat;
    wire [47:0] snap_flat;
    wire        slow_tick;
    wire        sel_cap;
    wire        sel_alm;
    wire        sel_ctrl;
    wire        sel_osc;
    wire        wr_ctrl;
    wire        alarm_hit;
    integer     i;

    genvar g;
    generate
        for (g = 0; g < `RTCC_BYTES; g = g + 1) begin : flat
            assign cap_flat[8*g+7:8*g] = capture_bytes_q[g];
            assign alm_flat[8*g+7:8*g] = alarm_bytes_q[g];
        end
    endgenerate

    function in_range;
        input [7:0] a;
        input [7:0] lo;
        input [7:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    // Rising edge of the synchronised slow clock marks one timer cycle
    assign slow_tick = slow_sync_q[1] & ~slow_sync_q[2];
    assign sel_cap   = in_range(address_q, `RTCC_ADR_CAP0, `RTCC_ADR_CAP5);
    assign sel_alm   = in_range(address_q, `RTCC_ADR_ALM0, `RTCC_ADR_ALM5);
    assign sel_ctrl  = (address_q == `RTCC_ADR_CTRL);
    assign sel_osc   = (address_q == `RTCC_ADR_OSC);
    assign wr_ctrl   = data_wr & sel_ctrl;
    // Timer LSB sits in bit 1 of the lowest capture byte
    assign snap_flat = {timer_q, 1'b0};
    assign alarm_hit = (timer_q >= alm_flat[47:1]);
    assign timer_value = timer_q;
    assign alarm_flag = alarm_flag_q;
    assign gain_control_enable = agc_q & crystal_mode_select_q;
    assign crystal_mode_select = crystal_mode_select_q;
    assign bias_double_enable = bias_q;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            slow_sync_q <= 3'h0;
            vld_sync_q  <= 2'h0;
            bat_sync_q  <= 2'h0;
        end else begin
            slow_sync_q <= {slow_sync_q[1:0], slow_clock};
            vld_sync_q  <= {vld_sync_q[0], clock_valid};
            bat_sync_q  <= {bat_sync_q[0], backup_supply_indicator};
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            address_q <= 8'h00;
            agc_q     <= 1'b0;
            crystal_mode_select_q   <= 1'b0;
            bias_q    <= 1'b0;
        end else begin
            if (addr_wr) begin
                address_q <= wdata;
            end
            // Status bits of this register are never stored
            if (data_wr && sel_osc) begin
                agc_q   <= wdata[`RTCC_OSC_AGC];
                crystal_mode_select_q <= wdata[`RTCC_OSC_CRYSTAL_MODE_SELECT];
                bias_q  <= wdata[`RTCC_OSC_BIAS];
            end
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            run_q   <= 1'b0;
            aen_q   <= 1'b0;
            set_q   <= 1'b0;
            cap_q   <= 1'b0;
            timer_q <= 47'h0;
        end else begin
            if (wr_ctrl) begin
                run_q <= wdata[`RTCC_CTRL_RUN];
                aen_q <= wdata[`RTCC_CTRL_AEN];
            end
            // Pending request bits ignore a written zero until done
            if (wr_ctrl && wdata[`RTCC_CTRL_SET]) begin
                set_q <= 1'b1;
            end
            if (wr_ctrl && wdata[`RTCC_CTRL_CAP]) begin
                cap_q <= 1'b1;
            end
            if (set_q) begin
                timer_q <= cap_flat[47:1];
                set_q   <= 1'b0;
            end else if (run_q && slow_tick) begin
                timer_q <= timer_q + 47'h1;
            end
            if (cap_q) begin
                cap_q <= 1'b0;
            end
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            for (i = 0; i < `RTCC_BYTES; i = i + 1) begin
                capture_bytes_q[i] <= `RTCC_CAP_RESET;
                alarm_bytes_q[i]   <= `RTCC_ALM_RESET;
            end
        end else begin
            if (data_wr && sel_cap) begin
                capture_bytes_q[address_q[2:0]] <= wdata;
            end
            if (data_wr && sel_alm) begin
                alarm_bytes_q[address_q[2:0]] <= wdata;
            end
            // snapshot timer, bit 0 unused
            // A snapshot overrides a byte written in the same cycle
            if (cap_q) begin
                for (i = 0; i < `RTCC_BYTES; i = i + 1) begin
                    capture_bytes_q[i] <= snap_flat[8*i +: 8];
                end
            end
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            alarm_flag_q <= 1'b0;
        end else if (aen_q && alarm_hit) begin
            alarm_flag_q <= 1'b1;
        end else if (wr_ctrl && !wdata[`RTCC_CTRL_ALARM_FLAG]) begin
            alarm_flag_q <= 1'b0;
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (data_rd) begin
            if (sel_cap) begin
                rdata <= capture_bytes_q[address_q[2:0]];
            end else if (sel_alm) begin
                rdata <= alarm_bytes_q[address_q[2:0]];
            end else if (sel_ctrl) begin
                rdata <= {3'h0, run_q, aen_q, alarm_flag_q, set_q, cap_q};
            end else if (sel_osc) begin
                // Valid reads high in self-oscillate mode
                rdata <= {agc_q, crystal_mode_select_q, bias_q,
                          vld_sync_q[1] | ~crystal_mode_select_q,
                          3'h0, bat_sync_q[1]};
            end else begin
                rdata <= 8'h00;
            end
        end
    end
endmodule

// file: rtcc_top_asserts.sv
`timescale 1ns/10ps
module rtcc_asserts (
    input wire        core_clk,
    input wire        sys_rst,
    input wire        addr_wr,
    input wire        data_wr,
    input wire        data_rd,
    input wire [7:0]  wdata,
    input wire [7:0]  rdata,
    input wire        gain_control_enable,
    input wire        crystal_mode_select,
    input wire        bias_double_enable,
    input wire        alarm_flag,
    input wire [46:0] timer_value
);
    reg  [7:0] adr_q;
    reg  [7:0] wd_q;
    reg  [1:0] osc_rd_q;
    reg        run_q;
    reg        aen_q;
    wire       ctl = data_wr && adr_q == 8'h06;
    wire       set_req = ctl && wdata[1];
    // Shadow of the control bits, since only ports are visible
    always @(posedge core_clk) begin
        wd_q     <= wdata;
        osc_rd_q <= {crystal_mode_select, bias_double_enable};
        if (sys_rst) begin
            adr_q          <= 8'h00;
            {run_q, aen_q} <= 2'b00;
        end else begin
            if (addr_wr)
                adr_q <= wdata;
            if (ctl)
                {run_q, aen_q} <= wdata[4:3];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_agc_xtal_only: assert property (
        gain_control_enable |-> crystal_mode_select) else $error("Gain off mode");
    a_osc_write_bits: assert property (
        data_wr && adr_q == 8'h07 |=>
        gain_control_enable == (wd_q[7] & wd_q[6]) &&
        crystal_mode_select == wd_q[6] && bias_double_enable == wd_q[5])
        else $error("Osc bits wrong");
    a_osc_read_back: assert property (
        data_rd && adr_q == 8'h07 |=> rdata[6:5] == osc_rd_q)
        else $error("Osc rd");
    a_timer_hold: assert property (
        !run_q && !set_req && !$past(set_req) |=> $stable(timer_value))
        else $error("Timer moved while stopped");
    a_timer_step: assert property (
        run_q && !set_req && !$past(set_req) |=> timer_value ==
        $past(timer_value) || timer_value == $past(timer_value) + 47'd1)
        else $error("Timer jumped");
    a_alarm_needs_en: assert property (
        $rose(alarm_flag) |-> $past(aen_q))
        else $error("Alarm without enable");
    a_alarm_sticky: assert property (
        alarm_flag && !(ctl && !wdata[2]) |=> alarm_flag)
        else $error("Alarm cleared by itself");
    a_read_stands: assert property (
        !data_rd |=> $stable(rdata)) else $error("Read data changed");
endmodule
bind rtcc_top rtcc_asserts chk (
    .core_clk            (core_clk),
    .sys_rst             (sys_rst),
    .addr_wr             (addr_wr),
    .data_wr             (data_wr),
    .data_rd             (data_rd),
    .wdata               (wdata),
    .rdata               (rdata),
    .gain_control_enable (gain_control_enable),
    .crystal_mode_select (crystal_mode_select),
    .bias_double_enable  (bias_double_enable),
    .alarm_flag          (alarm_flag),
    .timer_value         (timer_value)
);

// file: rtc_control_capture_alarm_tb_top.sv
`timescale 1ns/10ps
module rtc_control_capture_alarm_tb_top;
    reg         core_clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         slow_clock = 1'b0;
    reg         clock_valid = 1'b0;
    reg         backup_supply_indicator = 1'b0;
    reg         addr_wr = 1'b0;
    reg         data_wr = 1'b0;
    reg         data_rd = 1'b0;
    reg  [7:0]  wdata = 8'h00;
    wire [7:0]  rdata;
    wire        gain_control_enable;
    wire        crystal_mode_select;
    wire        bias_double_enable;
    wire        alarm_flag;
    wire [46:0] timer_value;
    integer     fail_count = 0;
    integer     comparisons = 0;
    integer     i;
    reg  [47:0] v;
    reg  [47:0] c;
    reg  [46:0] t;
    reg  [7:0]  d;
    reg  [31:0] u;
    always #4 core_clk = ~core_clk;
    rtcc_top dut (.core_clk, .sys_rst, .slow_clock, .clock_valid,
        .backup_supply_indicator, .addr_wr, .data_wr, .data_rd, .wdata,
        .rdata, .gain_control_enable, .crystal_mode_select,
        .bias_double_enable, .alarm_flag, .timer_value);
    // Valid always reads set in self-oscillate mode
    function [7:0] osc_exp(input [7:0] x, input cv, input bat);
        osc_exp = {x[7:5], cv | ~x[6], 3'h0, bat};
    endfunction
    task chk(input [47:0] got, input [47:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task pulse(input [2:0] k, input [7:0] x);
        @(negedge core_clk);
        wdata = x;
        {addr_wr, data_wr, data_rd} = k;
        @(negedge core_clk);
        {addr_wr, data_wr, data_rd} = 3'b000;
    endtask
    task wr(input [7:0] a, input [7:0] x);
        pulse(3'h4, a);
        pulse(3'h2, x);
    endtask
    task rd(input [7:0] a);
        pulse(3'h4, a);
        pulse(3'h1, 8'h00);
    endtask
    // Slow clock stands still between bursts so counts are exact
    task slow(input integer n);
        repeat (n) begin
            repeat (4) @(negedge core_clk);
            slow_clock = 1'b1;
            repeat (4) @(negedge core_clk);
            slow_clock = 1'b0;
        end
        repeat (6) @(negedge core_clk);
    endtask
    task results;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count = fail_count + 1;
        results;
    end
    initial begin
        i = $urandom(40);
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        for (i = 0; i < 6; i = i + 1) begin
            u = $urandom;
            d = i == 0 ? 8'hc0 : i == 1 ? 8'h80 : u[7:0];
            {clock_valid, backup_supply_indicator} = u[9:8];
            wr(8'h07, d);
            chk(gain_control_enable, d[7] & d[6]);
            chk(crystal_mode_select, d[6]);
            chk(bias_double_enable, d[5]);
            rd(8'h07);
            chk(rdata, osc_exp(d, u[9], u[8]));
        end
        u = $urandom;
        v = {u[15:0], $urandom};
        for (i = 0; i < 6; i = i + 1)
            wr(i[7:0], v[8*i +: 8]);
        wr(8'h06, 8'h02);
        rd(8'h06);
        chk(rdata, 8'h00);
        chk(timer_value, v[47:1]);
        wr(8'h06, 8'h10);
        slow(5);
        wr(8'h06, 8'h00);
        t = v[47:1] + 47'd5;
        slow(3);
        chk(timer_value, t);
        wr(8'h06, 8'h01);
        rd(8'h06);
        chk(rdata, 8'h00);
        c = {t, 1'b0};
        for (i = 0; i < 6; i = i + 1) begin
            rd(i[7:0]);
            chk(rdata & (i == 0 ? 8'hfe : 8'hff), c[8*i +: 8]);
            wr(i[7:0] + 8'h08, c[8*i +: 8]);
        end
        chk(alarm_flag, 1'b0);
        wr(8'h06, 8'h08);
        repeat (3) @(negedge core_clk);
        chk(alarm_flag, 1'b1);
        wr(8'h06, 8'h04);
        repeat (3) @(negedge core_clk);
        chk(alarm_flag, 1'b1);
        wr(8'h06, 8'h00);
        chk(alarm_flag, 1'b0);
        results;
    end
endmodule
